// File: spi_ctrl_defs.svh
`ifndef SPI_CTRL_DEFS_SVH
`define SPI_CTRL_DEFS_SVH

// Register offsets (byte addresses on the register port)
`define OFF_CONTROL       8'h00
`define OFF_DATA          8'h04
`define OFF_STATUS        8'h08

// Control word field positions
`define CTL_FRAMED        31
`define CTL_FRAME_EDGE    17
`define CTL_DEEP_BUF      16
`define CTL_ENABLE        15
`define CTL_HALT_IDLE     13
`define CTL_OUT_RELEASE   12
`define CTL_WIDTH_HI      11
`define CTL_WIDTH_LO      10
`define CTL_SAMPLE_PHASE  9
`define CTL_AUDIO         7
`define CTL_MASTER        5

// Control reset value and writable bits
`define CONTROL_RESET     32'h0000_0000
`define CONTROL_WMASK     32'h8003_BEA0

// Status field positions
`define ST_RX_VALID       0
`define ST_TX_FULL        1
`define ST_BUSY           2
`define ST_OVERFLOW       3
`define ST_RX_FULL        4

// Timing: master bit clock half period and system clock period
`define MCLK_PERIOD_NS    50
`define SCLK_HALF_NS      100
`define SCLK_HALF_CYC     ((`SCLK_HALF_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

// Receive buffer depth in enhanced mode
`define RX_DEPTH          2

`endif

// File: spi_ctrl_pkg.sv
package spi_ctrl_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FSYNC,
    ST_SHIFT
  } eng_state_t;

endpackage

// File: spi_ctrl_fields.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "spi_ctrl_defs.svh"

// How it works
// [R1] Framed master: edge field 1 pulses with first bit, 0 one bit earlier.
// [R2] Enhanced buffer bit 1 allows two receive entries, 0 only one.
// [R3] Enhanced buffer bit changes only while the module is off.
// [R4] Module enable bit 1 runs the engine, 0 holds it idle.
// [R5] Halt-in-idle set freezes the engine while the chip is idle.
// [R6] Release bit 1 lets go of the data output pin, 0 drives it while the module is enabled.
// [R7] Audio widths: 11 24/32, 10 32/32, 01 16/32, 00 16/16 data/channel.
// [R8] Normal widths: upper bit 32, pattern 01 16, pattern 00 8 bits.
// [R9] Master samples input at bit end when phase bit 1, middle when 0.
// [R10] Slave ignores the phase bit and always samples at bit middle.
module spi_ctrl_fields
  import spi_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_ff,
  // Chip power state
  input  wire logic        chip_idle,
  // Link pins
  input  wire logic        sclk_in,
  input  wire logic        sdi_in,
  output logic             sclk_out_ff,
  output logic             sclk_oe_n_ff,
  output logic             serial_data_out_pin_ff,
  output logic             serial_data_out_pin_oe_n_ff,
  output logic             frame_pulse_ff
);

  localparam int HALF_CYC = `SCLK_HALF_CYC;

  function automatic logic [5:0] chan_bits(input logic audio, input logic hi, input logic lo);
    if (audio)
      chan_bits = (hi || lo) ? 6'h20 : 6'h10;
    else
      chan_bits = hi ? 6'h20 : (lo ? 6'h10 : 6'h08);
  endfunction

  function automatic logic [5:0] data_bits(input logic audio, input logic hi, input logic lo);
    if (audio)
      data_bits = hi ? (lo ? 6'h18 : 6'h20) : 6'h10;
    else
      data_bits = hi ? 6'h20 : (lo ? 6'h10 : 6'h08);
  endfunction

  function automatic logic [31:0] rx_align(input logic [31:0] sh, input logic [5:0] chan,
                                           input logic [5:0] dat);
    logic [31:0] m;
    m = (dat == 6'h20) ? 32'hFFFF_FFFF : ((32'h0000_0001 << dat) - 32'h0000_0001);
    rx_align = (sh >> (chan - dat)) & m;
  endfunction

  // Control register and decoded fields
  logic [31:0] control_ff;
  logic        frame_edge_sel;
  logic        deep_buffer_enable;
  logic        enable;
  logic        halt_in_idle;
  logic        serial_out_release;
  logic        width_sel_hi;
  logic        width_sel_lo;
  logic        input_sample_phase;
  logic        audio_protocol_enable;
  logic        master_select;
  logic        framed;
  logic        run;
  logic [5:0]  chan_w;
  logic [5:0]  data_w;
  logic [4:0]  last_bit;
  logic        sample_end;

  assign frame_edge_sel        = control_ff[`CTL_FRAME_EDGE];
  assign deep_buffer_enable    = control_ff[`CTL_DEEP_BUF];
  assign enable                = control_ff[`CTL_ENABLE];
  assign halt_in_idle          = control_ff[`CTL_HALT_IDLE];
  assign serial_out_release    = control_ff[`CTL_OUT_RELEASE];
  assign width_sel_hi          = control_ff[`CTL_WIDTH_HI];
  assign width_sel_lo          = control_ff[`CTL_WIDTH_LO];
  assign input_sample_phase    = control_ff[`CTL_SAMPLE_PHASE];
  assign audio_protocol_enable = control_ff[`CTL_AUDIO];
  assign master_select         = control_ff[`CTL_MASTER];
  assign framed                = control_ff[`CTL_FRAMED];
  assign run                   = enable && !(halt_in_idle && chip_idle); // [R4] [R5]
  assign chan_w                = chan_bits(audio_protocol_enable, width_sel_hi, width_sel_lo); // [R7] [R8]
  assign data_w                = data_bits(audio_protocol_enable, width_sel_hi, width_sel_lo); // [R7] [R8]
  assign last_bit              = 5'(chan_w - 6'h01);
  assign sample_end            = master_select && input_sample_phase; // [R9] [R10]

  logic wr_ctl;
  logic wr_data;
  logic wr_stat;
  logic rd_data;
  assign wr_ctl  = reg_wr && (reg_addr == `OFF_CONTROL);
  assign wr_data = reg_wr && (reg_addr == `OFF_DATA);
  assign wr_stat = reg_wr && (reg_addr == `OFF_STATUS);
  assign rd_data = reg_rd && (reg_addr == `OFF_DATA);

  logic [31:0] nxt_control;
  always_comb begin
    nxt_control = reg_wdata & `CONTROL_WMASK;
    if (enable)
      nxt_control[`CTL_DEEP_BUF] = deep_buffer_enable; // [R3]
  end

  always_ff @(posedge mclk) begin
    if (sys_rst)
      control_ff <= `CONTROL_RESET;
    else if (wr_ctl)
      control_ff <= nxt_control;
  end

  // Pin synchronisers; the first stage feeds only the second
  logic sclk_s1_ff;
  logic sclk_s2_ff;
  logic sclk_s3_ff;
  logic sdi_s1_ff;
  logic sdi_s2_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      sdi_s1_ff  <= 1'b0;
      sdi_s2_ff  <= 1'b0;
    end else begin
      sclk_s1_ff <= sclk_in;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      sdi_s1_ff  <= sdi_in;
      sdi_s2_ff  <= sdi_s1_ff;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s2_ff && !sclk_s3_ff;
  assign sclk_fall = !sclk_s2_ff && sclk_s3_ff;

  // Transmit holding register
  logic [31:0] tx_hold_ff;
  logic        tx_full_ff;
  logic        tx_taken_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst || !enable) begin
      tx_hold_ff <= 32'h0000_0000;
      tx_full_ff <= 1'b0;
    end else if (tx_taken_ff) begin
      tx_full_ff <= 1'b0;
    end else if (wr_data && !tx_full_ff) begin
      tx_hold_ff <= reg_wdata;
      tx_full_ff <= 1'b1;
    end
  end

  // Receive buffer; depth follows the enhanced buffer bit
  logic [31:0] rx_mem_ff [`RX_DEPTH];
  logic        rx_wp_ff;
  logic        rx_rp_ff;
  logic [1:0]  rx_cnt_ff;
  logic        rx_full;
  logic        rx_in_valid;
  logic        rx_out_ready;
  logic        rx_push;
  logic        overflow_ff;
  logic        word_done_ff;
  logic [31:0] rx_sh_ff;

  assign rx_full      = (rx_cnt_ff == (deep_buffer_enable ? 2'd2 : 2'd1)); // [R2]
  assign rx_in_valid  = word_done_ff;
  assign rx_out_ready = rd_data && (rx_cnt_ff != 2'd0);
  assign rx_push      = rx_in_valid && !rx_full;

  always_ff @(posedge mclk) begin
    if (sys_rst || !enable) begin
      rx_wp_ff  <= 1'b0;
      rx_rp_ff  <= 1'b0;
      rx_cnt_ff <= 2'd0;
    end else begin
      if (rx_push) begin
        rx_mem_ff[rx_wp_ff] <= rx_align(rx_sh_ff, chan_w, data_w); // [R7] [R8]
        rx_wp_ff            <= !rx_wp_ff;
      end
      if (rx_out_ready)
        rx_rp_ff <= !rx_rp_ff;
      rx_cnt_ff <= rx_cnt_ff + {1'b0, rx_push} - {1'b0, rx_out_ready};
    end
  end

  // A word lost to a full buffer; the set beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst)
      overflow_ff <= 1'b0;
    else if (rx_in_valid && rx_full)
      overflow_ff <= 1'b1;
    else if (wr_stat && reg_wdata[`ST_OVERFLOW])
      overflow_ff <= 1'b0;
  end

  // Shift engine
  eng_state_t  state_ff;
  logic [4:0]  bit_cnt_ff;
  logic [3:0]  half_cnt_ff;
  logic        fs_half_ff;
  logic [31:0] tx_sh_ff;
  logic        tx_armed_ff;
  logic        tick;
  logic [31:0] shift_in;
  logic [31:0] tx_load;

  assign tick     = (half_cnt_ff == 4'(HALF_CYC - 1));
  assign shift_in = {rx_sh_ff[30:0], sdi_s2_ff};
  assign tx_load  = tx_full_ff ? (tx_hold_ff << (6'h20 - data_w)) : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (sys_rst || !enable) begin // [R4]
      state_ff     <= ST_IDLE;
      bit_cnt_ff   <= 5'd0;
      half_cnt_ff  <= 4'd0;
      fs_half_ff   <= 1'b0;
      sclk_out_ff  <= 1'b0;
      frame_pulse_ff <= 1'b0;
      tx_sh_ff     <= 32'h0000_0000;
      tx_armed_ff  <= 1'b0;
      rx_sh_ff     <= 32'h0000_0000;
      word_done_ff <= 1'b0;
      tx_taken_ff  <= 1'b0;
    end else if (!run) begin // [R5]
      word_done_ff <= 1'b0;
      tx_taken_ff  <= 1'b0;
    end else begin
      word_done_ff <= 1'b0;
      tx_taken_ff  <= 1'b0;
      if (master_select) begin
        case (state_ff)
          ST_IDLE: begin
            // Waiting on a full receive buffer stalls the next word
            if (tx_full_ff && !rx_full && !word_done_ff) begin
              tx_sh_ff    <= tx_load;
              tx_taken_ff <= 1'b1;
              rx_sh_ff    <= 32'h0000_0000;
              bit_cnt_ff  <= 5'd0;
              half_cnt_ff <= 4'd0;
              fs_half_ff  <= 1'b0;
              if (framed && !frame_edge_sel) begin // [R1]
                state_ff       <= ST_FSYNC;
                frame_pulse_ff <= 1'b1;
              end else begin
                state_ff       <= ST_SHIFT;
                frame_pulse_ff <= framed; // [R1]
              end
            end
          end
          ST_FSYNC: begin
            if (tick) begin
              half_cnt_ff <= 4'd0;
              fs_half_ff  <= !fs_half_ff;
              if (fs_half_ff) begin
                state_ff       <= ST_SHIFT;
                frame_pulse_ff <= 1'b0; // [R1]
              end
            end else begin
              half_cnt_ff <= half_cnt_ff + 4'd1;
            end
          end
          ST_SHIFT: begin
            if (tick) begin
              half_cnt_ff <= 4'd0;
              if (!sclk_out_ff) begin
                sclk_out_ff <= 1'b1;
                if (!sample_end)
                  rx_sh_ff <= shift_in; // [R9]
              end else begin
                sclk_out_ff    <= 1'b0;
                frame_pulse_ff <= 1'b0;
                if (sample_end)
                  rx_sh_ff <= shift_in; // [R9]
                if (bit_cnt_ff == last_bit) begin // [R7] [R8]
                  state_ff     <= ST_IDLE;
                  word_done_ff <= 1'b1;
                end else begin
                  bit_cnt_ff <= bit_cnt_ff + 5'd1;
                  tx_sh_ff   <= tx_sh_ff << 1;
                end
              end
            end else begin
              half_cnt_ff <= half_cnt_ff + 4'd1;
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end else begin
        sclk_out_ff    <= 1'b0;
        frame_pulse_ff <= 1'b0;
        state_ff       <= ST_SHIFT;
        if (state_ff != ST_SHIFT) begin
          tx_sh_ff    <= tx_load;
          tx_taken_ff <= tx_full_ff;
          tx_armed_ff <= tx_full_ff;
          bit_cnt_ff  <= 5'd0;
        end else if (sclk_rise) begin
          rx_sh_ff <= shift_in; // [R10]
          if (bit_cnt_ff == last_bit) begin // [R7] [R8]
            bit_cnt_ff   <= 5'd0;
            word_done_ff <= 1'b1;
            tx_sh_ff     <= tx_load;
            tx_taken_ff  <= tx_full_ff;
            tx_armed_ff  <= tx_full_ff;
          end else begin
            bit_cnt_ff <= bit_cnt_ff + 5'd1;
          end
        end else if (sclk_fall && bit_cnt_ff != 5'd0) begin
          tx_sh_ff <= tx_sh_ff << 1;
        end else if (bit_cnt_ff == 5'd0 && !tx_armed_ff && tx_full_ff && !tx_taken_ff) begin
          // A word written before the first bit clock still goes out whole
          tx_sh_ff    <= tx_load;
          tx_taken_ff <= 1'b1;
          tx_armed_ff <= 1'b1;
        end
      end
    end
  end

  // Pin drivers; the bit clock pin is only driven as master
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serial_data_out_pin_ff      <= 1'b0;
      serial_data_out_pin_oe_n_ff <= 1'b1;
      sclk_oe_n_ff                <= 1'b1;
    end else begin
      serial_data_out_pin_ff      <= tx_sh_ff[31];
      serial_data_out_pin_oe_n_ff <= serial_out_release || !enable; // [R6]
      sclk_oe_n_ff                <= !(enable && master_select);
    end
  end

  // Read port: data only in the cycle after the strobe
  logic [31:0] status_w;
  assign status_w = {27'h000_0000, rx_full, overflow_ff, (state_ff != ST_IDLE),
                     tx_full_ff, (rx_cnt_ff != 2'd0)};

  always_ff @(posedge mclk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        `OFF_CONTROL: reg_rdata_ff <= control_ff;
        `OFF_DATA:    reg_rdata_ff <= (rx_cnt_ff != 2'd0) ? rx_mem_ff[rx_rp_ff] : 32'h0000_0000;
        `OFF_STATUS:  reg_rdata_ff <= status_w;
        default:      reg_rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_fsync_lead: assert property ((state_ff == ST_FSYNC) |-> frame_pulse_ff && !sclk_out_ff) // [R1]
    else $error("frame pulse missing before first bit clock");

  a_fsync_with: assert property ($rose(frame_pulse_ff) && master_select && frame_edge_sel
                                 |-> state_ff == ST_SHIFT ##1 state_ff == ST_SHIFT) // [R1]
    else $error("frame pulse not aligned with first bit clock");

  a_rx_depth_cap: assert property (rx_cnt_ff <= (deep_buffer_enable ? 2'd2 : 2'd1)) // [R2]
    else $error("receive buffer holds more than its mode allows");

  a_deep_locked: assert property (enable |=> deep_buffer_enable == $past(deep_buffer_enable)) // [R3]
    else $error("deep buffer bit changed while enabled");

  a_off_quiet: assert property (!enable |=> state_ff == ST_IDLE && !sclk_out_ff && !word_done_ff) // [R4]
    else $error("engine active while disabled");

  a_idle_freeze: assert property (enable && halt_in_idle && chip_idle
                                  |=> $stable(state_ff) && $stable(bit_cnt_ff) && $stable(rx_sh_ff)) // [R5]
    else $error("engine moved during idle halt");

  a_sdo_release: assert property (##1 serial_data_out_pin_oe_n_ff == $past(serial_out_release || !enable)) // [R6]
    else $error("data out enable does not follow release bit");

  a_audio_width: assert property (word_done_ff && audio_protocol_enable
                                  |-> $past(bit_cnt_ff) == ((width_sel_hi || width_sel_lo) ? 5'd31 : 5'd15)) // [R7]
    else $error("audio channel length wrong");

  a_plain_width: assert property (word_done_ff && !audio_protocol_enable && master_select
                                  |-> $past(bit_cnt_ff) == (width_sel_hi ? 5'd31 : (width_sel_lo ? 5'd15 : 5'd7))) // [R8]
    else $error("word length wrong");

  a_end_sample: assert property (run && master_select && sample_end && state_ff == ST_SHIFT && tick
                                 && !sclk_out_ff |=> $stable(rx_sh_ff)) // [R9]
    else $error("end-phase master sampled at mid bit");

  a_slave_mid: assert property (run && !master_select && state_ff == ST_SHIFT && sclk_fall
                                |=> $stable(rx_sh_ff)) // [R10]
    else $error("slave sampled away from mid bit");

endmodule
`default_nettype wire

// File: spi_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_peer_model (
  // Link as seen at the pins
  input  wire logic        sclk_line,
  input  wire logic        sdo_line,
  // Settings from the bench
  input  wire logic        shift_on_rise,
  input  wire logic [5:0]  n_bits,
  input  wire logic [31:0] tx_word,
  // Peer drives
  output logic             sclk_in,
  output logic             sdi_in,
  output logic [31:0]      rx_word
);
  logic       mastering;
  logic [5:0] cnt;

  initial begin
    sclk_in = 1'b0;
    sdi_in = 1'b0;
    rx_word = '0;
    cnt = '0;
    mastering = 1'b0;
  end

  // Preload the first bit: the block's first sample can come before any shift edge
  task automatic load();
    mastering = 1'b0;
    cnt = '0;
    rx_word = '0;
    sdi_in = tx_word[n_bits - 6'd1];
  endtask

  task automatic next_bit();
    cnt = (cnt + 6'd1 == n_bits) ? 6'd0 : cnt + 6'd1;
    sdi_in = tx_word[n_bits - 6'd1 - cnt];
  endtask

  always @(posedge sclk_line) begin
    if (!mastering) begin
      rx_word = {rx_word[30:0], sdo_line};
      if (shift_on_rise) next_bit();
    end
  end

  always @(negedge sclk_line) if (!mastering && !shift_on_rise) next_bit();

  // Peer as clock source: 400 ns bit period, clock still outside words
  task automatic run_master(input logic [5:0] n, input logic [31:0] w);
    mastering = 1'b1;
    rx_word = '0;
    for (int i = int'(n) - 1; i >= 0; i--) begin
      sdi_in = w[i];
      #200 sclk_in = 1'b1;
      rx_word = {rx_word[30:0], sdo_line};
      // Hold time is over: the line stops showing the bit, so a late sampler reads garbage
      #100 sdi_in = ~w[i];
      #100 sclk_in = 1'b0;
    end
    #200 sdi_in = ~sdi_in;
  endtask
endmodule
`default_nettype wire

// File: spi_ctrl_fields_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "spi_ctrl_defs.svh"
module spi_ctrl_fields_tb_top;
  logic        mclk, sys_rst, reg_wr, reg_rd, chip_idle;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, peer_tx, peer_rx;
  logic        sclk_out_ff, sclk_oe_n_ff, sdo_ff, sdo_oe_n_ff, frame_pulse_ff;
  logic        peer_sclk, peer_sdi, peer_rise, sclk_q, fp_first;
  logic [5:0]  peer_n;
  wire logic   sclk_line, sdo_line;
  int          err_count = 0;
  int          n_checks = 0;
  int          rise_cnt, fp_pre;
  logic [5:0]  nbits [4] = '{6'd8, 6'd16, 6'd32, 6'd32};
  logic [5:0]  chan [4] = '{6'd16, 6'd32, 6'd32, 6'd32};
  logic [5:0]  pad [4] = '{6'd0, 6'd16, 6'd0, 6'd8};

  // Shared bit clock pin; the data out pin floats when released
  assign sclk_line = sclk_oe_n_ff ? peer_sclk : sclk_out_ff;
  assign sdo_line = sdo_oe_n_ff ? 1'bz : sdo_ff;

  spi_ctrl_fields i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .chip_idle(chip_idle),
    .sclk_in(sclk_line), .sdi_in(peer_sdi), .sclk_out_ff(sclk_out_ff), .sclk_oe_n_ff(sclk_oe_n_ff),
    .serial_data_out_pin_ff(sdo_ff), .serial_data_out_pin_oe_n_ff(sdo_oe_n_ff),
    .frame_pulse_ff(frame_pulse_ff));

  spi_peer_model i_peer (.sclk_line(sclk_line), .sdo_line(sdo_line), .shift_on_rise(peer_rise),
    .n_bits(peer_n), .tx_word(peer_tx), .sclk_in(peer_sclk), .sdi_in(peer_sdi), .rx_word(peer_rx));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (sclk_out_ff && !sclk_q) begin
      if (rise_cnt == 0) fp_first = frame_pulse_ff;
      rise_cnt++;
    end
    if (rise_cnt == 0 && frame_pulse_ff) fp_pre++;
    sclk_q = sclk_out_ff;
  end

  function automatic logic [31:0] mk(input logic [5:0] n);
    mk = (n == 6'd32) ? 32'hFFFF_FFFF : (32'h0000_0001 << n) - 32'h0000_0001;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask

  task automatic wait_rx();
    logic [31:0] s;
    s = '0;
    for (int i = 0; i < 300 && !s[0]; i++) rd(`OFF_STATUS, s);
    chk("rx valid", 32'h0000_0001, s & 32'h0000_0001);
  endtask

  task automatic master_xfer(input logic [31:0] ctl, input logic [5:0] n, input logic [31:0] tx, pw);
    logic [31:0] d;
    peer_n = n;
    peer_tx = pw;
    peer_rise = !ctl[`CTL_SAMPLE_PHASE];
    #1 i_peer.load();
    wr(`OFF_CONTROL, ctl);
    rise_cnt = 0;
    fp_pre = 0;
    wr(`OFF_DATA, tx);
    if (ctl[`CTL_HALT_IDLE]) begin
      repeat (100) @(posedge mclk);
      chk("bit clocks while halted", 32'h0000_0000, 32'(rise_cnt));
      chip_idle <= 1'b0;
    end
    wait_rx();
    rd(`OFF_DATA, d);
    chk("master rx word", pw & mk(n), d);
    chk("bit clocks", 32'(n), 32'(rise_cnt));
    chk("out release", {31'h0, ctl[`CTL_OUT_RELEASE]}, {31'h0, sdo_oe_n_ff});
    if (!ctl[`CTL_OUT_RELEASE]) chk("peer rx word", tx & mk(n), peer_rx & mk(n));
  endtask

  task automatic slave_xfer(input logic [31:0] ctl, input logic [5:0] c, p, input logic [31:0] tx, pw);
    logic [31:0] d;
    wr(`OFF_CONTROL, ctl);
    wr(`OFF_DATA, tx);
    #13 i_peer.run_master(c, pw);
    wait_rx();
    rd(`OFF_DATA, d);
    chk("slave rx word", (pw >> p) & mk(c - p), d);
    chk("slave tx word", tx & mk(c - p), (peer_rx & mk(c)) >> p);
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] d;
    {reg_wr, reg_rd, chip_idle, peer_rise, sclk_q, fp_first} = '0;
    {reg_addr, reg_wdata, peer_tx, peer_n, rise_cnt, fp_pre} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1 chk("pins after reset", 32'h3, {27'h0, sclk_out_ff, frame_pulse_ff, sdo_ff, sclk_oe_n_ff, sdo_oe_n_ff});
    rd(`OFF_CONTROL, d);
    chk("control reset", `CONTROL_RESET, d);
    wr(`OFF_CONTROL, 32'hFFFF_FFFF);
    rd(`OFF_CONTROL, d);
    chk("control all ones", `CONTROL_WMASK, d);
    chk("pins when on", 32'h0000_0001, {30'h0, sclk_oe_n_ff, sdo_oe_n_ff});
    wr(`OFF_CONTROL, 32'h0000_0000);
    rd(`OFF_CONTROL, d);
    chk("deep bit kept while on", 32'h0001_0000, d);
    chk("pins when off", 32'h0000_0003, {30'h0, sclk_oe_n_ff, sdo_oe_n_ff});
    wr(`OFF_CONTROL, 32'h0000_0000);
    rd(`OFF_CONTROL, d);
    chk("deep bit cleared while off", 32'h0000_0000, d);
    rd(8'hFC, d);
    chk("unmapped read", 32'h0000_0000, d);
    chip_idle <= 1'b1;
    for (int w = 0; w < 4; w++) begin
      master_xfer(32'h0000_8020 | (32'(w) << `CTL_WIDTH_LO), nbits[w], 32'hC3A5_5A3C + 32'(w), 32'h9B1D_E472 ^ 32'(w));
    end
    master_xfer(32'h0000_8620, 6'd16, 32'h0000_B00C, 32'h0000_7E81);
    master_xfer(32'h0000_9020, 6'd8, 32'h0000_00C5, 32'h0000_003A);
    for (int e = 0; e < 2; e++) begin
      master_xfer(32'h8000_8020 | (32'(e) << `CTL_FRAME_EDGE), 6'd8, 32'h0000_0096, 32'h0000_0069);
      chk("pulse at first clock", 32'(e), {31'h0, fp_first});
      if (e == 0) chk("pulse lead cycles", 32'h0000_0004, 32'(fp_pre));
    end
    master_xfer(32'h0000_A020, 6'd8, 32'h0000_005A, 32'h0000_00E7);
    for (int w = 0; w < 4; w++) begin
      slave_xfer(32'h0000_8280 | (32'(w) << `CTL_WIDTH_LO), chan[w], pad[w], 32'h1234_5678 ^ 32'(w), 32'hA1B2_C3D4 + 32'(w));
    end
    for (int b = 0; b < 2; b++) begin
      wr(`OFF_CONTROL, 32'h0000_0000);
      wr(`OFF_CONTROL, 32'h0000_8000 | (32'(b) << `CTL_DEEP_BUF));
      for (int k = 1; k <= b + 2; k++) i_peer.run_master(6'd8, 32'h0000_0011 * 32'(k));
      rd(`OFF_STATUS, d);
      chk("status after overflow", 32'h0000_001D, d);
      for (int k = 1; k <= b + 1; k++) begin
        rd(`OFF_DATA, d);
        chk("buffered word", 32'h0000_0011 * 32'(k), d);
      end
      wr(`OFF_STATUS, 32'h0000_0008);
      rd(`OFF_STATUS, d);
      chk("status after clear", 32'h0000_0004, d);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
